// [common/tape_status_pkg.sv]
// constants and carrier types for the tape exception status unit
`default_nettype none
package tape_status_pkg;
	// ----------------------------------------
	// status byte layout
	// ----------------------------------------
	localparam int unsigned status_byte_count = 6;
	localparam logic [2:0] status_last_index = 3'h5;
	localparam int unsigned counter_width = 16;
	// bit positions in an exception byte; bit 7 goes out as bit 15
	localparam int unsigned bit_hi_top = 7; // reset occurred / file mark
	localparam int unsigned bit_b0_failed_block = 6;
	localparam int unsigned bit_b0_irrec = 5;
	localparam int unsigned bit_b0_tape_end = 4;
	localparam int unsigned bit_b0_wprot = 3;
	localparam int unsigned bit_b0_noline = 2;
	localparam int unsigned bit_b0_nocart = 1;
	localparam int unsigned bit_summary = 0;
	localparam int unsigned bit_b1_nodata = 2;
	localparam int unsigned bit_b1_illegal = 1;
	localparam logic [7:0] byte1_reserved_mask = 8'h78;
	localparam logic [7:0] flags_reset_low = 8'h00;
	localparam logic [7:0] flags_reset_high = 8'h81;
	localparam logic [15:0] count_reset = 16'h0000;
	localparam logic [15:0] count_one = 16'h0001;
	localparam logic [15:0] count_two = 16'h0002;
	// read-status command code on the command byte
	localparam logic [7:0] cmd_read_status = 8'h00;

	// ----------------------------------------
	// carrier types
	// ----------------------------------------
	typedef struct packed {
		logic write_protected;   // level: plug in safe position
		logic drive_offline;     // level: selected drive absent/unpowered
		logic no_cartridge;      // level: cartridge not in place
	} drive_levels_t;

	typedef struct packed {
		logic file_mark;         // pulse
		logic block_not_found;   // pulse, with irrecoverable
		logic irrecoverable;     // pulse
		logic end_of_tape;       // pulse
		logic no_data;           // pulse: timeout irrecoverable
		logic illegal_command;   // pulse: command checker verdict
		logic rewrite_block;     // pulse: one block rewritten
		logic read_retry;        // pulse: one crc retry
		logic write_underrun;    // pulse: next block due, buffer not full
		logic read_underrun;     // pulse: no empty buffer
	} tape_events_t;

	typedef struct packed {
		logic is_select;
		logic is_position;
		logic is_write;
		logic is_write_fm;
		logic is_read;
		logic is_read_fm;
		logic [3:0] operand;     // drive or qualifier one-hot field
	} cmd_info_t;

	typedef enum logic [2:0] {
		st_idle = 3'b001,
		st_present = 3'b010,
		st_wait_drop = 3'b100
	} xfer_state_t;
endpackage
`default_nettype wire

// [hw/illegal_cmd_check.sv]
// combinational judge of whether an accepted command is illegal
`default_nettype none
module illegal_cmd_check (
	input wire tape_status_pkg::cmd_info_t cmd_i, // decoded command
	input wire logic online_i,                    // on-line control bit
	input wire logic write_busy_i,                // write command executing
	output logic illegal_o                        // verdict
);
	function automatic logic not_one_hot(input logic [3:0] v);
		return (v == 4'h0) || ((v & (v - 4'h1)) != 4'h0);
	endfunction

	logic data_cmd;
	logic write_cmd;
	always_comb begin
		data_cmd = cmd_i.is_write | cmd_i.is_write_fm |
			cmd_i.is_read | cmd_i.is_read_fm;
		write_cmd = cmd_i.is_write | cmd_i.is_write_fm;
		illegal_o = 1'b0;
		// RULE7 select drive count
		if (cmd_i.is_select && not_one_hot(cmd_i.operand))
			illegal_o = 1'b1;
		// RULE8 position qualifier count
		if (cmd_i.is_position && not_one_hot(cmd_i.operand))
			illegal_o = 1'b1;
		// RULE10 data command offline
		if (data_cmd && !online_i)
			illegal_o = 1'b1;
		// RULE9 foreign command mid-write
		if (write_busy_i && !write_cmd)
			illegal_o = 1'b1;
	end
endmodule
`default_nettype wire

// [hw/tape_exception_status_unit.sv]
// exception flags, error statistics and six-byte read-status transfer
//
// Contract
// RULE1 - write-protect level sets byte0 bit 11
// RULE2 - absent or unpowered drive sets bit 10
// RULE3 - missing cartridge sets byte0 bit 9
// RULE4 - byte0 bit 8 summary, cleared by status
// RULE5 - reset sets byte1 bit 15, reserved zero
// RULE6 - no-data timeout sets byte1 bit 10
// RULE7 - bad select drive count is illegal
// RULE8 - bad position qualifier count is illegal
// RULE9 - non-write command during write illegal
// RULE10 - data command while offline is illegal
// RULE11 - byte1 bit 8 summary, cleared by status
// RULE12 - data-error count sent high then low
// RULE13 - online control output clears error count
// RULE14 - each rewritten block adds one
// RULE15 - each crc read retry adds one
// RULE16 - underrun count sent high then low
// RULE17 - write underrun stops tape, counts one
// RULE18 - read underrun stops tape, counts one
// RULE19 - read status returns six bytes 0..5
// RULE20 - direction, ready per byte, request answers
// RULE21 - exception out while any summary set
`default_nettype none
module tape_exception_status_unit (
	input wire logic ref_clk_i,                       // 50 MHz clock
	input wire logic resetn_i,                        // sync reset, low
	input wire logic [7:0] cmd_data_i,                // command byte in
	input wire logic cmd_req_i,                       // processor request
	input wire logic cmd_is_status_i,                 // cmd byte is read-status
	input wire tape_status_pkg::cmd_info_t cmd_info_i, // decoded other command
	input wire logic online_i,                        // on-line control bit
	input wire logic ctl_out_strobe_i,                // control output pulse
	input wire logic write_busy_i,                    // write executing
	input wire tape_status_pkg::drive_levels_t levels_i, // pin levels
	input wire tape_status_pkg::tape_events_t events_i,  // same-clock events
	output logic [7:0] status_data_o,                 // status byte out
	output logic status_ready_o,                      // ready for a byte
	output logic cmd_ack_o,                           // other command taken
	output logic transfer_direction_flag_o,           // 1: device to cpu
	output logic exception_o,                         // overall exception
	output logic stop_tape_o,                         // halt tape motion
	output logic illegal_seen_o                       // last verdict
);
	// ----------------------------------------
	// pin synchronisers for drive levels
	// ----------------------------------------
	// only lvl_q feeds logic; the first stage may still be settling
	tape_status_pkg::drive_levels_t lvl_meta_q;
	tape_status_pkg::drive_levels_t lvl_q;
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			lvl_meta_q <= '0;
			lvl_q <= '0;
		end else begin
			lvl_meta_q <= levels_i;
			lvl_q <= lvl_meta_q;
		end
	end

	// ----------------------------------------
	// command handshake and status transfer
	// ----------------------------------------
	tape_status_pkg::xfer_state_t state_q;
	logic [2:0] index_q;
	logic req_q;
	logic status_done;
	logic other_take;
	logic illegal;

	assign other_take = (state_q == tape_status_pkg::st_idle) && cmd_req_i &&
		!req_q && !cmd_is_status_i;
	// completes when the processor drops request after the sixth byte
	assign status_done = (state_q == tape_status_pkg::st_wait_drop) &&
		!cmd_req_i && (index_q == tape_status_pkg::status_last_index);

	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i)
			req_q <= 1'b0;
		else
			req_q <= cmd_req_i;
	end

	// RULE19 six bytes in order
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			state_q <= tape_status_pkg::st_idle;
			index_q <= 3'h0;
		end else begin
			unique case (state_q)
			tape_status_pkg::st_idle: begin
				index_q <= 3'h0;
				if (cmd_req_i && !req_q && cmd_is_status_i &&
					cmd_data_i == tape_status_pkg::cmd_read_status)
					state_q <= tape_status_pkg::st_wait_drop;
			end
			tape_status_pkg::st_present: begin
				if (cmd_req_i)
					state_q <= tape_status_pkg::st_wait_drop;
			end
			tape_status_pkg::st_wait_drop: begin
				// leave on the last drop so the index never runs past five
				if (!cmd_req_i) begin
					if (index_q == tape_status_pkg::status_last_index)
						state_q <= tape_status_pkg::st_idle;
					else if (!status_ready_o) begin
						state_q <= tape_status_pkg::st_present;
						if (transfer_direction_flag_o)
							index_q <= index_q + 3'h1;
					end
				end
			end
			default: state_q <= tape_status_pkg::st_idle;
			endcase
		end
	end

	// ----------------------------------------
	// flags
	// ----------------------------------------
	logic [7:0] flags_low_q;
	logic [7:0] flags_high_q;
	logic [7:0] low_view;
	logic [7:0] high_view;

	illegal_cmd_check u_check (
		.cmd_i(cmd_info_i),
		.online_i(online_i),
		.write_busy_i(write_busy_i),
		.illegal_o(illegal)
	);

	always_comb begin
		low_view = flags_low_q;
		// RULE1 write-protect level
		low_view[tape_status_pkg::bit_b0_wprot] = lvl_q.write_protected;
		// RULE2 drive presence level
		low_view[tape_status_pkg::bit_b0_noline] = lvl_q.drive_offline;
		// RULE3 cartridge level
		low_view[tape_status_pkg::bit_b0_nocart] = lvl_q.no_cartridge;
		// RULE4 byte0 summary
		low_view[tape_status_pkg::bit_summary] =
			flags_low_q[tape_status_pkg::bit_summary] |
			(|low_view[7:1]);
		high_view = flags_high_q & ~tape_status_pkg::byte1_reserved_mask;
		// RULE11 byte1 summary
		high_view[tape_status_pkg::bit_summary] =
			flags_high_q[tape_status_pkg::bit_summary] |
			(|high_view[7:1]);
	end

	// sticky event bits: an event in the clearing cycle survives
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			flags_low_q <= tape_status_pkg::flags_reset_low;
		end else begin
			// RULE4 status clears byte0
			if (status_done)
				flags_low_q <= tape_status_pkg::flags_reset_low;
			if (events_i.file_mark)
				flags_low_q[tape_status_pkg::bit_hi_top] <= 1'b1;
			if (events_i.block_not_found)
				flags_low_q[tape_status_pkg::bit_b0_failed_block] <= 1'b1;
			if (events_i.irrecoverable || events_i.no_data)
				flags_low_q[tape_status_pkg::bit_b0_irrec] <= 1'b1;
			if (events_i.end_of_tape)
				flags_low_q[tape_status_pkg::bit_b0_tape_end] <= 1'b1;
			if (events_i.file_mark || events_i.block_not_found ||
				events_i.irrecoverable || events_i.no_data ||
				events_i.end_of_tape)
				flags_low_q[tape_status_pkg::bit_summary] <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			// RULE5 reset reported
			flags_high_q <= tape_status_pkg::flags_reset_high;
		end else begin
			// RULE11 status clears byte1
			if (status_done)
				flags_high_q <= tape_status_pkg::flags_reset_low;
			// RULE6 no-data timeout
			if (events_i.no_data) begin
				flags_high_q[tape_status_pkg::bit_b1_nodata] <= 1'b1;
				flags_high_q[tape_status_pkg::bit_summary] <= 1'b1;
			end
			// RULE7 own verdict or one reported from outside
			if ((other_take && illegal) ||
				events_i.illegal_command) begin
				flags_high_q[tape_status_pkg::bit_b1_illegal] <= 1'b1;
				flags_high_q[tape_status_pkg::bit_summary] <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// statistics counters
	// ----------------------------------------
	// both counts wrap past the top; nothing saturates them
	logic [15:0] err_count_q;
	logic [15:0] under_count_q;
	logic [15:0] err_step;
	logic [15:0] under_step;

	always_comb begin
		err_step = tape_status_pkg::count_reset;
		// RULE14 rewritten block
		if (events_i.rewrite_block)
			err_step = err_step + tape_status_pkg::count_one;
		// RULE15 crc read retry
		if (events_i.read_retry)
			err_step = err_step + tape_status_pkg::count_one;
		under_step = tape_status_pkg::count_reset;
		if (events_i.write_underrun || events_i.read_underrun)
			under_step = (events_i.write_underrun &&
				events_i.read_underrun) ? tape_status_pkg::count_two :
				tape_status_pkg::count_one;
	end

	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i)
			err_count_q <= tape_status_pkg::count_reset;
		// RULE13 online control output clears
		else if (ctl_out_strobe_i && online_i)
			err_count_q <= tape_status_pkg::count_reset;
		else
			err_count_q <= err_count_q + err_step;
	end

	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i)
			under_count_q <= tape_status_pkg::count_reset;
		// RULE17 write underrun counted
		else
			under_count_q <= under_count_q + under_step;
	end

	// RULE18 read underrun halts tape
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i)
			stop_tape_o <= 1'b0;
		else
			stop_tape_o <= events_i.write_underrun ||
				events_i.read_underrun;
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	function automatic logic [7:0] pick_byte(input logic [2:0] i,
		input logic [7:0] b0, input logic [7:0] b1,
		input logic [15:0] e, input logic [15:0] u);
		unique case (i)
		3'h0: return b0;
		3'h1: return b1;
		// RULE12 error count high first
		3'h2: return e[15:8];
		3'h3: return e[7:0];
		// RULE16 underrun count high first
		3'h4: return u[15:8];
		default: return u[7:0];
		endcase
	endfunction

	// ready falls on the edge that sees request, so each byte goes once
	// RULE20 direction and ready handshake
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			transfer_direction_flag_o <= 1'b0;
			status_ready_o <= 1'b0;
			status_data_o <= 8'h00;
			cmd_ack_o <= 1'b0;
		end else begin
			cmd_ack_o <= other_take || (cmd_ack_o && cmd_req_i);
			if (status_done)
				transfer_direction_flag_o <= 1'b0;
			else if (state_q == tape_status_pkg::st_present)
				transfer_direction_flag_o <= 1'b1;
			status_ready_o <= (state_q == tape_status_pkg::st_present)
				&& !cmd_req_i;
			status_data_o <= pick_byte(index_q, low_view, high_view,
				err_count_q, under_count_q);
		end
	end

	// RULE21 overall exception
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			exception_o <= 1'b1;
			illegal_seen_o <= 1'b0;
		end else begin
			exception_o <= !status_done &&
				(low_view[tape_status_pkg::bit_summary] ||
				high_view[tape_status_pkg::bit_summary]);
			if (other_take)
				illegal_seen_o <= illegal;
		end
	end
endmodule
`default_nettype wire

// [tb/status_unit_asserts.sv]
// assertions on the ports of the tape exception status unit
`default_nettype none
module status_unit_asserts (
	input wire logic ref_clk_i, // clock
	input wire logic resetn_i, // sync reset, low
	input wire logic cmd_req_i, // request
	input wire logic cmd_is_status_i, // status command
	input wire tape_status_pkg::tape_events_t events_i, // events
	input wire tape_status_pkg::drive_levels_t levels_i, // pin levels
	input wire logic [7:0] status_data_o, // status byte
	input wire logic status_ready_o, // ready
	input wire logic transfer_direction_flag_o, // direction
	input wire logic exception_o, // exception
	input wire logic stop_tape_o // tape halt
);
	// ----------------------------------------
	// ready rises seen in one transfer
	// ----------------------------------------
	logic [2:0] rises_q;
	logic rdy_q;
	always_ff @(posedge ref_clk_i) begin
		rdy_q <= status_ready_o;
		if (!resetn_i || !transfer_direction_flag_o) begin
			rises_q <= 3'h0;
		end else if (status_ready_o && !rdy_q) begin
			rises_q <= rises_q + 3'h1;
		end
	end
	a_reset_exception: assert property (@(posedge ref_clk_i)
		$rose(resetn_i) |-> exception_o && !transfer_direction_flag_o)
		else $error("exception not raised after reset");
	a_ready_in_dir: assert property (@(posedge ref_clk_i)
		disable iff (!resetn_i) status_ready_o |-> transfer_direction_flag_o)
		else $error("ready outside a status transfer");
	a_ready_holds: assert property (@(posedge ref_clk_i)
		disable iff (!resetn_i)
		status_ready_o && !cmd_req_i |=> status_ready_o)
		else $error("ready dropped without request");
	a_byte_stable: assert property (@(posedge ref_clk_i)
		disable iff (!resetn_i)
		status_ready_o && $past(status_ready_o) |-> $stable(status_data_o))
		else $error("status byte changed while ready");
	a_six_bytes: assert property (@(posedge ref_clk_i)
		disable iff (!resetn_i)
		$fell(transfer_direction_flag_o) |-> rises_q == 3'h6)
		else $error("transfer did not offer six bytes");
	a_stop_tape: assert property (@(posedge ref_clk_i)
		disable iff (!resetn_i) stop_tape_o ==
		$past(events_i.write_underrun || events_i.read_underrun))
		else $error("tape halt does not follow underrun");
	a_exc_clear: assert property (@(posedge ref_clk_i)
		disable iff (!resetn_i) $fell(exception_o) |->
		$past(transfer_direction_flag_o) || $past(transfer_direction_flag_o, 2)
		|| $past(transfer_direction_flag_o, 3)
		|| ($past(levels_i, 4) != '0))
		else $error("exception dropped without status read");
	a_exc_on_level: assert property (@(posedge ref_clk_i)
		disable iff (!resetn_i) ($past(levels_i, 3) != '0) |->
		exception_o || $past(transfer_direction_flag_o))
		else $error("exception low while a drive level is set");
	a_dir_cause: assert property (@(posedge ref_clk_i)
		disable iff (!resetn_i) $rose(transfer_direction_flag_o) |->
		$past(cmd_is_status_i) || $past(cmd_is_status_i, 2) ||
		$past(cmd_is_status_i, 3) || $past(cmd_is_status_i, 4) ||
		$past(cmd_is_status_i, 5))
		else $error("direction raised without status command");
endmodule
bind tape_exception_status_unit status_unit_asserts u_asserts (.ref_clk_i,
	.resetn_i, .cmd_req_i, .cmd_is_status_i, .events_i, .levels_i,
	.status_data_o,
	.status_ready_o, .transfer_direction_flag_o, .exception_o, .stop_tape_o);
`default_nettype wire

// [tb/host_cpu_model.sv]
// processor model issuing commands and reading status
`default_nettype none
module host_cpu_model (
	input wire logic clk_i, // bench clock
	input wire logic [7:0] data_i, // status byte
	input wire logic rdy_i, // device ready
	input wire logic dir_i, // direction
	input wire logic ack_i, // command taken
	output var logic [7:0] cmd_data_o, // command byte
	output var logic cmd_req_o, // request
	output var logic cmd_is_status_o, // status marker
	output var tape_status_pkg::cmd_info_t cmd_info_o // decoded command
);
	timeunit 1ns;
	timeprecision 100ps;
	int faults = 0;
	initial begin
		cmd_data_o = 8'h00;
		cmd_req_o = 1'b0;
		cmd_is_status_o = 1'b0;
		cmd_info_o = '0;
	end
	// sel 0 direction, 1 ready, 2 ack; a hang counts as a fault
	task automatic await(input int sel, input logic v);
		int n;
		logic x;
		n = 0;
		do begin
			@(posedge clk_i);
			x = (sel == 0) ? dir_i : (sel == 1) ? rdy_i : ack_i;
			n++;
		end while (x !== v && n < 100);
		if (x !== v) faults++;
	endtask
	task automatic issue_cmd(input tape_status_pkg::cmd_info_t info);
		@(posedge clk_i);
		#1;
		cmd_info_o = info;
		cmd_data_o = 8'h01;
		cmd_req_o = 1'b1;
		await(2, 1'b1);
		#1 cmd_req_o = 1'b0;
		cmd_data_o = ~cmd_data_o;
		await(2, 1'b0);
		#1;
	endtask
	task automatic read_status(output logic [47:0] s);
		@(posedge clk_i);
		#1;
		cmd_data_o = tape_status_pkg::cmd_read_status;
		cmd_is_status_o = 1'b1;
		cmd_req_o = 1'b1;
		@(posedge clk_i);
		#1;
		cmd_req_o = 1'b0;
		cmd_is_status_o = 1'b0;
		cmd_data_o = ~cmd_data_o;
		for (int i = 0; i < 6; i++) begin
			await(1, 1'b1);
			s = {s[39:0], data_i};
			#1 cmd_req_o = 1'b1;
			await(1, 1'b0);
			#1 cmd_req_o = 1'b0;
		end
		await(0, 1'b0);
		#1;
	endtask
endmodule
`default_nettype wire

// [tb/tape_exception_status_unit_tb.sv]
// self-checking bench for the tape exception status unit
`default_nettype none
module tape_exception_status_unit_tb;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct packed {
		tape_status_pkg::tape_events_t ev;
		logic [3:0] reps;
		logic [7:0] b0;
		logic [7:0] b1;
		logic [15:0] err;
		logic [15:0] und;
	} row_t;
	logic ref_clk_i, resetn_i, cmd_req_i, cmd_is_status_i, online_i;
	logic ctl_out_strobe_i, write_busy_i, status_ready_o, cmd_ack_o;
	logic transfer_direction_flag_o, exception_o, stop_tape_o, illegal_seen_o;
	logic [7:0] cmd_data_i, status_data_o;
	tape_status_pkg::cmd_info_t cmd_info_i;
	tape_status_pkg::drive_levels_t levels_i;
	tape_status_pkg::tape_events_t events_i;
	logic [47:0] s;
	row_t rows [7];
	logic [11:0] ilg [5];
	int num_errors = 0;
	int tests_run = 0;
	int cycles = 0;
	tape_exception_status_unit dut (.ref_clk_i, .resetn_i, .cmd_data_i,
		.cmd_req_i, .cmd_is_status_i, .cmd_info_i, .online_i,
		.ctl_out_strobe_i, .write_busy_i, .levels_i, .events_i,
		.status_data_o, .status_ready_o, .cmd_ack_o,
		.transfer_direction_flag_o, .exception_o, .stop_tape_o,
		.illegal_seen_o);
	host_cpu_model host (.clk_i(ref_clk_i), .data_i(status_data_o),
		.rdy_i(status_ready_o), .dir_i(transfer_direction_flag_o),
		.ack_i(cmd_ack_o), .cmd_data_o(cmd_data_i), .cmd_req_o(cmd_req_i),
		.cmd_is_status_o(cmd_is_status_i), .cmd_info_o(cmd_info_i));
	initial begin
		ref_clk_i = 1'b0;
		forever #10 ref_clk_i = ~ref_clk_i;
	end
	task automatic check(input string what, input logic [15:0] seen, exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask
	always @(posedge ref_clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			report_and_stop();
		end
	end
	initial begin
		// pulses: rewrite, retry, write/read underrun, rewrite with retry, no data, illegal
		rows = '{'{10'h008, 4'h2, 8'h00, 8'h81, 16'h0002, 16'h0000},
			'{10'h004, 4'h3, 8'h00, 8'h00, 16'h0005, 16'h0000},
			'{10'h002, 4'h1, 8'h00, 8'h00, 16'h0005, 16'h0001},
			'{10'h001, 4'h2, 8'h00, 8'h00, 16'h0005, 16'h0003},
			'{10'h00c, 4'h1, 8'h00, 8'h00, 16'h0007, 16'h0003},
			'{10'h020, 4'h1, 8'h21, 8'h05, 16'h0007, 16'h0003},
			'{10'h010, 4'h1, 8'h00, 8'h03, 16'h0007, 16'h0003}};
		// {command, online, write busy}; the last one is legal
		ilg = '{{10'h200, 2'b10}, {10'h103, 2'b10}, {10'h080, 2'b00},
			{10'h020, 2'b11}, {10'h202, 2'b10}};
		resetn_i = 1'b0;
		online_i = 1'b1;
		ctl_out_strobe_i = 1'b0;
		write_busy_i = 1'b0;
		levels_i = '0;
		events_i = '0;
		idle(10);
		resetn_i = 1'b1;
		foreach (rows[r]) begin
			for (int k = 0; k < rows[r].reps; k++) begin
				idle(1);
				events_i = rows[r].ev;
				idle(1);
				events_i = '0;
			end
			idle(4);
			check("exception", exception_o, |{rows[r].b0, rows[r].b1});
			host.read_status(s);
			check("byte0", s[47:40], rows[r].b0);
			check("byte1", s[39:32], rows[r].b1);
			check("error count", s[31:16], rows[r].err);
			check("underrun count", s[15:0], rows[r].und);
		end
		$display("event rows done");
		foreach (ilg[i]) begin
			{online_i, write_busy_i} = ilg[i][1:0];
			host.issue_cmd(ilg[i][11:2]);
			check("illegal verdict", illegal_seen_o, i < 4);
			online_i = 1'b1;
			write_busy_i = 1'b0;
			host.read_status(s);
			check("illegal flag", s[39:32], i < 4 ? 8'h03 : 8'h00);
		end
		$display("illegal commands done");
		for (int i = 0; i < 3; i++) begin
			levels_i = 3'b100 >> i;
			idle(6);
			host.read_status(s);
			check("level byte0", s[47:40], (8'h08 >> i) | 8'h01);
			host.read_status(s);
			check("level kept", s[47:40], (8'h08 >> i) | 8'h01);
			levels_i = '0;
			idle(6);
			host.read_status(s);
			check("level gone", s[47:40], 8'h00);
		end
		$display("drive levels done");
		ctl_out_strobe_i = 1'b1;
		idle(1);
		ctl_out_strobe_i = 1'b0;
		idle(2);
		host.read_status(s);
		check("cleared count", s[31:16], 16'h0000);
		check("kept underruns", s[15:0], 16'h0003);
		$display("counter clear done");
		resetn_i = 1'b0;
		idle(2);
		resetn_i = 1'b1;
		host.read_status(s);
		check("reset byte1", s[39:32], 8'h81);
		check("reset underruns", s[15:0], 16'h0000);
		idle(4);
		check("exception after read", exception_o, 1'b0);
		check("host handshake", host.faults[15:0], 16'h0000);
		$display("second reset done");
		report_and_stop();
	end
endmodule
`default_nettype wire
